// [rtl/gpc_map.svh]
`ifndef GPC_MAP_SVH
`define GPC_MAP_SVH
// ----------------------------------------------------------------
// address map
// ----------------------------------------------------------------
`define GPC_ROM_LAST      16'h3FFF
`define GPC_ROM_DEPTH     16384
`define GPC_VEC_SLOTS     11
`define GPC_TABLE_CALL_INSTRUCTION_BASE    14'h0040
`define GPC_FIXED_AREA_CALL_INSTRUCTION_BASE    14'h0800
`define GPC_RAM_FIRST     16'hFE40
`define GPC_RAM_LAST      16'hFEFF
`define GPC_RAM_DEPTH     192
`define GPC_RAM_LOW       8'h40
`define GPC_GPR_FIRST     8'hE0
`define GPC_SFR_PAGE      8'hFF
`define GPC_STACK_PAGE    8'hFE
`define GPC_SP_GUARD      8'h3F
// ----------------------------------------------------------------
// status word layout and reset value
// ----------------------------------------------------------------
`define GPC_PSW_RESET     8'h02
`define GPC_PSW_IE        7
`define GPC_PSW_Z         6
`define GPC_PSW_BSH       5
`define GPC_PSW_AC        4
`define GPC_PSW_BSL       3
`define GPC_PSW_ZERO_BIT  2
`define GPC_PSW_ONE_BIT   1
`define GPC_PSW_CY        0
// ----------------------------------------------------------------
// register port offsets
// ----------------------------------------------------------------
`define GPC_REG_PSW       4'h0
`define GPC_REG_SP        4'h1
`define GPC_REG_PC_LOW    4'h2
`define GPC_REG_PC_HIGH   4'h3
`define GPC_REG_STATUS    4'h4
`endif

// [rtl/gpc_pkg.sv]
`include "gpc_map.svh"
package gpc_pkg;
  // reset/vector loader states, gray along the usual path
  typedef enum logic [1:0] {
    GPC_ST_RESET   = 2'b00,
    GPC_ST_LOAD_LO = 2'b01,
    GPC_ST_LOAD_HI = 2'b11,
    GPC_ST_RUN     = 2'b10
  } gpcState_e;
  // kind of flag update asked by the execution unit
  typedef enum logic [2:0] {
    GPC_FLG_NONE  = 3'h0,
    GPC_FLG_ADD   = 3'h1,
    GPC_FLG_SUB   = 3'h2,
    GPC_FLG_SHIFT = 3'h3,
    GPC_FLG_BIT   = 3'h4,
    GPC_FLG_LOGIC = 3'h5
  } gpcFlagKind_e;
  typedef struct packed {
    gpcFlagKind_e kind;
    logic [7:0]   opA;
    logic [7:0]   opB;
    logic         carryIn;
    logic         bitValue;
  } gpcAluReq_s;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        write;
    logic        read;
  } gpcMemReq_s;
endpackage : gpc_pkg

// [rtl/gpc_core_state.sv]
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "gpc_map.svh"
module gpc_core_state
  import gpc_pkg::*;
(
  // clock and reset
  input  wire  logic        mclk,
  input  wire  logic        reset,
  // mask ROM programming
  input  wire  logic        romProgWrite,
  input  wire  logic [13:0] romProgAddr,
  input  wire  logic [7:0]  romProgData,
  // data memory access
  input  wire  gpcMemReq_s  memReq,
  input  wire  logic        sfrAssigned,
  input  wire  logic [7:0]  sfrRdata,
  output var   logic [7:0]  memRdata,
  output var   logic        memFault,
  output var   logic        sfrWrite,
  output var   logic        sfrRead,
  output var   logic [7:0]  sfrOffset,
  output var   logic [7:0]  sfrWdata,
  // register port
  input  wire  logic [3:0]  regAddr,
  input  wire  logic [7:0]  regWdata,
  input  wire  logic        regWrite,
  input  wire  logic        regRead,
  output var   logic [7:0]  regRdata,
  // program counter control
  input  wire  logic        pcAdvance,
  input  wire  logic [2:0]  pcAdvLen,
  input  wire  logic        pcLoad,
  input  wire  logic [13:0] pcLoadValue,
  input  wire  logic        tableCall,
  input  wire  logic [4:0]  tableIndex,
  input  wire  logic        fixedCall,
  input  wire  logic [10:0] fixedOffset,
  output var   logic [13:0] programCounter,
  output var   logic        coreReady,
  // stack and status word transfers
  input  wire  logic        stackPush,
  input  wire  logic [7:0]  stackWdata,
  input  wire  logic        stackPop,
  input  wire  logic        pushStatus,
  input  wire  logic        popStatus,
  output var   logic [7:0]  stackRdata,
  output var   logic [7:0]  stackPointer,
  // flag updates and interrupt control
  input  wire  gpcAluReq_s  aluReq,
  input  wire  logic        enableIntExec,
  input  wire  logic        disableIntExec,
  input  wire  logic        instrBoundary,
  input  wire  logic        watchdogRequest,
  input  wire  logic [8:0]  maskedRequests,
  output var   logic [7:0]  programStatusWord,
  output var   logic        intAccepted,
  output var   logic [3:0]  intSlot,
  // banked register access
  input  wire  logic [2:0]  gprIndex,
  input  wire  logic        gprPair,
  input  wire  logic        gprWrite,
  input  wire  logic [15:0] gprWdata,
  output var   logic [15:0] gprRdata,
  output var   logic [1:0]  activeBank
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0]  rom [0:`GPC_ROM_DEPTH-1];
  logic [7:0]  ram [0:`GPC_RAM_DEPTH-1];
  gpcState_e   state;
  gpcState_e   next_state;
  logic [13:0] fetchBase;
  logic [7:0]  fetchLow;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // region hits on the data bus
  wire         romHit  = (memReq.addr <= `GPC_ROM_LAST);
  wire         ramHit  = (memReq.addr >= `GPC_RAM_FIRST) &&
                         (memReq.addr <= `GPC_RAM_LAST);
  wire         sfrHit  = (memReq.addr[15:8] == `GPC_SFR_PAGE);
  wire         sfrOk   = sfrHit && sfrAssigned;
  wire [7:0]   memIdx  = memReq.addr[7:0] - `GPC_RAM_LOW;
  wire         memAny  = memReq.read || memReq.write;
  wire         badAcc  = memAny && !(romHit && !memReq.write) &&
                         !ramHit && !sfrOk;

  // stack addresses on page FE, push goes one below
  wire [7:0]   spDown  = stackPointer - 8'h01;
  wire [7:0]   spUp    = stackPointer + 8'h01;
  wire         pushAny = stackPush || pushStatus;
  wire         popAny  = stackPop || popStatus;
  wire         pushOk  = (spDown > `GPC_SP_GUARD);
  wire         popOk   = (stackPointer > `GPC_SP_GUARD);
  wire [7:0]   pushIdx = spDown - `GPC_RAM_LOW;
  wire [7:0]   popIdx  = stackPointer - `GPC_RAM_LOW;
  wire [7:0]   pushVal = pushStatus ? programStatusWord : stackWdata;
  wire [7:0]   popVal  = popOk ? ram[popIdx] : 8'h00;

  // bank base: bank 3 at E0, bank 0 at F8
  wire [1:0]   bankSel = {programStatusWord[`GPC_PSW_BSH],
                          programStatusWord[`GPC_PSW_BSL]};
  wire [7:0]   gprLow  = `GPC_GPR_FIRST + {3'h0, ~bankSel, 3'h0};
  wire [2:0]   gprEven = {gprIndex[2:1], 1'b0};
  wire [2:0]   gprByte = gprPair ? gprEven : gprIndex;
  wire [7:0]   gprIdx  = gprLow + {5'h00, gprByte} - `GPC_RAM_LOW;
  wire [7:0]   gprIdxH = gprIdx + 8'h01;

  // ----------------------------------------------------------------
  // flag arithmetic
  // ----------------------------------------------------------------
  // nine-bit sum and difference give carry or borrow
  wire [8:0]   addFull = {1'b0, aluReq.opA} + {1'b0, aluReq.opB} +
                         {8'h00, aluReq.carryIn};
  wire [8:0]   subFull = {1'b0, aluReq.opA} - {1'b0, aluReq.opB} -
                         {8'h00, aluReq.carryIn};
  wire [4:0]   addNib  = {1'b0, aluReq.opA[3:0]} + {1'b0, aluReq.opB[3:0]} +
                         {4'h0, aluReq.carryIn};
  wire [4:0]   subNib  = {1'b0, aluReq.opA[3:0]} - {1'b0, aluReq.opB[3:0]} -
                         {4'h0, aluReq.carryIn};
  wire         isAdd   = (aluReq.kind == GPC_FLG_ADD);
  wire         isSub   = (aluReq.kind == GPC_FLG_SUB);
  wire         isArith = isAdd || isSub;
  wire         isShift = (aluReq.kind == GPC_FLG_SHIFT);
  wire         isBit   = (aluReq.kind == GPC_FLG_BIT);
  wire         isLogic = (aluReq.kind == GPC_FLG_LOGIC);
  wire [7:0]   arithRes = isAdd ? addFull[7:0] : subFull[7:0];
  wire         newCarry = isAdd ? addFull[8] :
                          isSub ? subFull[8] : aluReq.bitValue;
  wire         newAux   = isAdd ? addNib[4] : subNib[4];
  wire [7:0]   zeroSrc  = isArith ? arithRes : aluReq.opA;
  wire         newZero  = (zeroSrc == 8'h00);
  wire         updCarry = isArith || isShift || isBit;
  wire         updZero  = isArith || isLogic;

  // ----------------------------------------------------------------
  // interrupt selection
  // ----------------------------------------------------------------
  // lowest slot wins among enabled maskable sources
  logic [3:0]  maskSlot;
  always_comb begin
    maskSlot = 4'h0;
    for (int i = 8; i >= 0; i--) begin
      if (maskedRequests[i]) begin
        maskSlot = 4'(i + 2);
      end
    end
  end
  wire         ieFlag  = programStatusWord[`GPC_PSW_IE];
  wire         maskGo  = ieFlag && (maskedRequests != 9'h000);
  wire         takeInt = (state == GPC_ST_RUN) && instrBoundary &&
                         (watchdogRequest || maskGo);
  wire [3:0]   takeSlot = watchdogRequest ? 4'h1 : maskSlot;
  wire [13:0]  slotBase = {9'h000, takeSlot, 1'b0};
  wire [13:0]  callBase = `GPC_TABLE_CALL_INSTRUCTION_BASE + {8'h00, tableIndex, 1'b0};
  wire [13:0]  fixedTgt = `GPC_FIXED_AREA_CALL_INSTRUCTION_BASE | {3'h0, fixedOffset};

  // ----------------------------------------------------------------
  // vector loader state machine
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      GPC_ST_RESET:   next_state = GPC_ST_LOAD_LO;
      GPC_ST_LOAD_LO: next_state = GPC_ST_LOAD_HI;
      GPC_ST_LOAD_HI: next_state = GPC_ST_RUN;
      GPC_ST_RUN: begin
        if (takeInt || tableCall) begin
          next_state = GPC_ST_LOAD_LO;
        end
      end
      default:        next_state = GPC_ST_RESET;
    endcase
  end

  // state and the address whose two bytes are being fetched
  always_ff @(posedge mclk) begin
    if (reset) begin
      state     <= GPC_ST_RESET;
      fetchBase <= 14'h0000;
    end else begin
      state <= next_state;
      if (takeInt) begin
        fetchBase <= slotBase;
      end else if (state == GPC_ST_RUN && tableCall) begin
        fetchBase <= callBase;
      end
    end
  end

  // low vector byte held until the high byte arrives
  always_ff @(posedge mclk) begin
    if (reset) begin
      fetchLow <= 8'h00;
    end else if (state == GPC_ST_LOAD_LO) begin
      fetchLow <= rom[fetchBase];
    end
  end

  // ----------------------------------------------------------------
  // program counter
  // ----------------------------------------------------------------
  wire [13:0]  vecHigh = fetchBase | 14'h0001;
  wire [13:0]  vecPc   = {rom[vecHigh][5:0], fetchLow};
  wire [13:0]  advPc   = programCounter + {11'h000, pcAdvLen};
  always_ff @(posedge mclk) begin
    if (reset) begin
      programCounter <= 14'h0000;
    end else if (state == GPC_ST_LOAD_HI) begin
      programCounter <= vecPc;
    end else if (state == GPC_ST_RUN && !takeInt && !tableCall) begin
      if (fixedCall) begin
        programCounter <= fixedTgt;
      end else if (pcLoad) begin
        programCounter <= pcLoadValue;
      end else if (pcAdvance) begin
        programCounter <= advPc;
      end
    end
  end

  // ----------------------------------------------------------------
  // status word
  // ----------------------------------------------------------------
  logic [7:0] next_psw;
  always_comb begin
    next_psw = programStatusWord;
    if (popStatus && popOk) begin
      next_psw = popVal;
    end else if (regWrite && regAddr == `GPC_REG_PSW) begin
      next_psw = regWdata;
    end else begin
      if (updCarry) begin
        next_psw[`GPC_PSW_CY] = newCarry;
      end
      if (isArith) begin
        next_psw[`GPC_PSW_AC] = newAux;
      end
      if (updZero) begin
        next_psw[`GPC_PSW_Z] = newZero;
      end
      if (enableIntExec) begin
        next_psw[`GPC_PSW_IE] = 1'b1;
      end
      if (disableIntExec) begin
        next_psw[`GPC_PSW_IE] = 1'b0;
      end
    end
    // acceptance clears the enable whatever else lands in this cycle
    if (takeInt) begin
      next_psw[`GPC_PSW_IE] = 1'b0;
    end
    next_psw[`GPC_PSW_ZERO_BIT] = 1'b0;
    next_psw[`GPC_PSW_ONE_BIT]  = 1'b1;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      programStatusWord <= `GPC_PSW_RESET;
    end else begin
      programStatusWord <= next_psw;
    end
  end

  // ----------------------------------------------------------------
  // stack pointer, no reset on purpose
  // ----------------------------------------------------------------
  wire         spRegWr = regWrite && (regAddr == `GPC_REG_SP);
  always_ff @(posedge mclk) begin
    if (spRegWr) begin
      stackPointer <= regWdata;
    end else if (pushAny || takeInt) begin
      stackPointer <= spDown;
    end else if (popAny) begin
      stackPointer <= spUp;
    end
  end

  // ----------------------------------------------------------------
  // mask ROM and data RAM writes
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (romProgWrite) begin
      rom[romProgAddr] <= romProgData;
    end
  end

  // bus, then register, then stack: the later write wins a clash
  wire         stackWr = (pushAny || takeInt) && pushOk && !spRegWr;
  always_ff @(posedge mclk) begin
    if (memReq.write && ramHit) begin
      ram[memIdx] <= memReq.wdata;
    end
    if (gprWrite) begin
      ram[gprIdx] <= gprWdata[7:0];
      if (gprPair) begin
        ram[gprIdxH] <= gprWdata[15:8];
      end
    end
    if (stackWr) begin
      ram[pushIdx] <= takeInt ? programStatusWord : pushVal;
    end
  end

  // ----------------------------------------------------------------
  // data bus answers, one cycle after the strobe
  // ----------------------------------------------------------------
  wire [7:0]   memData = romHit ? rom[memReq.addr[13:0]] :
                         ramHit ? ram[memIdx] : 8'h00;
  always_ff @(posedge mclk) begin
    if (reset) begin
      memRdata  <= 8'h00;
      memFault  <= 1'b0;
      sfrWrite  <= 1'b0;
      sfrRead   <= 1'b0;
      sfrOffset <= 8'h00;
      sfrWdata  <= 8'h00;
    end else begin
      memRdata  <= memReq.read ? memData : 8'h00;
      memFault  <= badAcc;
      sfrWrite  <= memReq.write && sfrOk;
      sfrRead   <= memReq.read && sfrOk;
      sfrOffset <= memReq.addr[7:0];
      sfrWdata  <= memReq.wdata;
    end
  end

  // ----------------------------------------------------------------
  // register port, stack and bank answers
  // ----------------------------------------------------------------
  wire [7:0]   statusView = {5'h00, coreReady, bankSel};
  wire [7:0]   regData = (regAddr == `GPC_REG_PSW)     ? programStatusWord :
                         (regAddr == `GPC_REG_SP)      ? stackPointer :
                         (regAddr == `GPC_REG_PC_LOW)  ? programCounter[7:0] :
                         (regAddr == `GPC_REG_PC_HIGH) ? {2'h0, programCounter[13:8]} :
                         (regAddr == `GPC_REG_STATUS)  ? statusView : 8'h00;
  wire [15:0]  gprData = gprPair ? {ram[gprIdxH], ram[gprIdx]} :
                                   {8'h00, ram[gprIdx]};
  always_ff @(posedge mclk) begin
    if (reset) begin
      regRdata    <= 8'h00;
      stackRdata  <= 8'h00;
      gprRdata    <= 16'h0000;
      activeBank  <= 2'h0;
      coreReady   <= 1'b0;
      intAccepted <= 1'b0;
      intSlot     <= 4'h0;
    end else begin
      regRdata    <= regRead ? regData : 8'h00;
      stackRdata  <= stackPop ? popVal : stackRdata;
      gprRdata    <= gprData;
      activeBank  <= bankSel;
      coreReady   <= (next_state == GPC_ST_RUN);
      intAccepted <= takeInt;
      intSlot     <= takeInt ? takeSlot : intSlot;
    end
  end

endmodule : gpc_core_state
`default_nettype wire

// [tb/gpc_core_state_checker.sv]
`timescale 1ns/100ps
`default_nettype none
module gpc_core_state_checker
  import gpc_pkg::*;
(
  // clock and reset
  input wire logic        mclk,
  input wire logic        reset,
  // data side
  input wire gpcMemReq_s  memReq,
  input wire logic        sfrAssigned,
  input wire logic        memFault,
  input wire logic        sfrRead,
  // stack
  input wire logic        regWrite,
  input wire logic        stackPush,
  input wire logic        stackPop,
  input wire logic [7:0]  stackPointer,
  // flow and status
  input wire logic        fixedCall,
  input wire logic        tableCall,
  input wire logic [10:0] fixedOffset,
  input wire logic [13:0] programCounter,
  input wire logic        coreReady,
  input wire logic        instrBoundary,
  input wire logic        watchdogRequest,
  input wire logic [7:0]  programStatusWord,
  input wire logic        intAccepted,
  input wire logic [3:0]  intSlot
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  // loader still busy for the first two edges after release
  sequence boot_s;
    !coreReady ##1 !coreReady;
  endsequence

  // status word, boot, decode, stack, flow and interrupt checks
  psw_reset_a: assert property (disable iff (1'b0) reset |=> programStatusWord == 8'h02)
    else $error("status word not 02 after reset");
  psw_fixed_a: assert property (programStatusWord[2:1] == 2'b01)
    else $error("status word fixed bits wrong");
  boot_ready_a: assert property ($fell(reset) |-> boot_s ##[1:2] coreReady)
    else $error("core not ready after vector load");
  map_hole_a: assert property (((memReq.read || memReq.write) &&
    memReq.addr inside {[16'h4000:16'hFE3F]}) || (memReq.write && memReq.addr <= 16'h3FFF)
    |=> memFault) else $error("hole or rom write not refused");
  sfr_refuse_a: assert property (memReq.read && memReq.addr[15:8] == 8'hFF &&
    !sfrAssigned |=> memFault && !sfrRead) else $error("unassigned sfr access passed");
  stack_push_a: assert property (stackPush && !stackPop && !regWrite && !instrBoundary
    |=> stackPointer == $past(stackPointer) - 8'h01) else $error("push did not decrement");
  fixed_call_a: assert property (coreReady && fixedCall && !tableCall && !instrBoundary
    |=> programCounter == {3'b001, $past(fixedOffset)}) else $error("fixed call target wrong");
  wdog_take_a: assert property (coreReady && instrBoundary && watchdogRequest
    |=> intAccepted && intSlot == 4'h1 && !programStatusWord[7]) else $error("watchdog not taken");
endmodule : gpc_core_state_checker

bind gpc_core_state gpc_core_state_checker gpc_core_state_checker_i (
  .mclk              (mclk),
  .reset             (reset),
  .memReq            (memReq),
  .sfrAssigned       (sfrAssigned),
  .memFault          (memFault),
  .sfrRead           (sfrRead),
  .regWrite          (regWrite),
  .stackPush         (stackPush),
  .stackPop          (stackPop),
  .stackPointer      (stackPointer),
  .fixedCall         (fixedCall),
  .tableCall         (tableCall),
  .fixedOffset       (fixedOffset),
  .programCounter    (programCounter),
  .coreReady         (coreReady),
  .instrBoundary     (instrBoundary),
  .watchdogRequest   (watchdogRequest),
  .programStatusWord (programStatusWord),
  .intAccepted       (intAccepted),
  .intSlot           (intSlot)
);
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/100ps
`default_nettype none
module tb;
  import gpc_pkg::*;
  // design ports
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic        romProgWrite, sfrAssigned, regWrite, regRead, pcAdvance, pcLoad;
  logic        tableCall, fixedCall, stackPush, stackPop, pushStatus, popStatus;
  logic        enableIntExec, disableIntExec, instrBoundary, watchdogRequest;
  logic        gprPair, gprWrite, memFault, sfrWrite, sfrRead, coreReady, intAccepted;
  logic [1:0]  activeBank;
  logic [2:0]  pcAdvLen, gprIndex;
  logic [3:0]  regAddr, intSlot;
  logic [4:0]  tableIndex;
  logic [8:0]  maskedRequests;
  logic [10:0] fixedOffset;
  logic [11:0] strb;
  logic [13:0] romProgAddr, pcLoadValue, programCounter, p;
  logic [15:0] gprWdata, gprRdata, w;
  logic [7:0]  romProgData, sfrRdata, regWdata, stackWdata, memRdata, sfrOffset, sfrWdata;
  logic [7:0]  regRdata, stackRdata, stackPointer, programStatusWord, mpsw, a, b, d;
  logic [8:0]  r;
  gpcMemReq_s  memReq;
  gpcAluReq_s  aluReq;
  logic [7:0]  rom [int];
  int          errors = 0;
  int          checks_done = 0;
  int          romAt [8] = '{0, 1, 2, 3, 10, 11, 126, 127};

  gpc_core_state gpc_core_state_i (.*);
  // one-cycle control strobes
  assign {tableCall, fixedCall, pcLoad, pcAdvance, stackPush, stackPop, pushStatus,
          popStatus, enableIntExec, disableIntExec, instrBoundary, gprWrite} = strb;
  always #2.5 mclk = ~mclk;

  task automatic cmp(input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmp
  // register port cycle, read data checked in the following cycle
  task automatic reg_op(input logic [3:0] ad, input logic wr, input logic [7:0] v);
    @(posedge mclk);
    {regAddr, regWdata, regWrite, regRead} <= {ad, v, wr, !wr};
    @(posedge mclk);
    {regWrite, regRead} <= 2'b00;
    #1;
    if (!wr) cmp(v, regRdata);
  endtask : reg_op
  // data bus cycle with fault and read data check
  task automatic mem_op(input logic [15:0] ad, input logic wr, input logic [7:0] v, input logic f);
    @(posedge mclk);
    memReq <= '{ad, v, wr, !wr};
    sfrAssigned <= (ad == 16'hFF28);
    @(posedge mclk);
    memReq <= '0;
    sfrAssigned <= 1'b0;
    #1;
    cmp(f, memFault);
    if (!wr) cmp(v, memRdata);
  endtask : mem_op
  task automatic fire(input logic [11:0] s);
    @(posedge mclk);
    strb <= s;
    @(posedge mclk);
    strb <= '0;
    #1;
  endtask : fire
  task automatic settle();
    for (int n = 0; n < 8 && coreReady !== 1'b1; n++) begin
      @(posedge mclk);
      #1;
    end
  endtask : settle
  function automatic logic [13:0] pcv(input int ad);
    return {rom[ad + 1][5:0], rom[ad]};
  endfunction : pcv
  task automatic complete_run();
    $display("checks_done %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  // cuts a hang short
  initial begin
    #50000;
    errors++;
    complete_run();
  end

  // main sequence
  initial begin
    {romProgWrite, romProgAddr, romProgData, memReq, sfrAssigned, sfrRdata, regAddr} = '0;
    {regWdata, regWrite, regRead, pcAdvLen, pcLoadValue, tableIndex, fixedOffset} = '0;
    {stackWdata, aluReq, watchdogRequest, maskedRequests, gprIndex, gprPair, gprWdata, strb} = '0;
    void'($urandom(32'h770b97bb));
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    reg_op(4'h1, 1'b1, 8'hC3);
    foreach (romAt[k]) begin
      rom[romAt[k]] = 8'($urandom);
      @(posedge mclk);
      {romProgWrite, romProgAddr, romProgData} <= {1'b1, romAt[k][13:0], rom[romAt[k]]};
    end
    @(posedge mclk);
    romProgWrite <= 1'b0;
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    settle();
    p = pcv(0);
    cmp(p, programCounter);
    reg_op(4'h1, 1'b0, 8'hC3);
    reg_op(4'h3, 1'b0, {2'b00, p[13:8]});
    reg_op(4'h9, 1'b1, 8'h5A);
    reg_op(4'h9, 1'b0, 8'h00);
    repeat (4) begin
      d = 8'($urandom);
      mpsw = (d & 8'hF9) | 8'h02;
      reg_op(4'h0, 1'b1, d);
      reg_op(4'h0, 1'b0, mpsw);
      reg_op(4'h4, 1'b0, {6'h01, mpsw[5], mpsw[3]});
    end
    // each bank: byte via data bus, pair via register path
    for (int bk = 0; bk < 4; bk++) begin
      mpsw = {2'b00, bk[1], 1'b0, bk[0], 3'b010};
      reg_op(4'h0, 1'b1, mpsw);
      a = 8'hE0 + 8'((3 - bk) * 8);
      d = 8'($urandom);
      w = 16'($urandom);
      mem_op({8'hFE, a + 8'h05}, 1'b1, d, 1'b0);
      {gprIndex, gprPair, gprWdata} <= {3'h5, 1'b0, w};
      @(posedge mclk);
      #1;
      cmp(d, gprRdata[7:0]);
      cmp(bk[1:0], activeBank);
      {gprIndex, gprPair} <= {3'h2, 1'b1};
      fire(12'h001);
      mem_op({8'hFE, a + 8'h02}, 1'b0, w[7:0], 1'b0);
      mem_op({8'hFE, a + 8'h03}, 1'b0, w[15:8], 1'b0);
    end
    mem_op(16'h0000, 1'b0, rom[0], 1'b0);
    mem_op(16'h3FFF, 1'b1, 8'h11, 1'b1);
    mem_op(16'h4000, 1'b0, 8'h00, 1'b1);
    mem_op(16'hFE3F, 1'b0, 8'h00, 1'b1);
    mem_op(16'hFF28, 1'b0, 8'h00, 1'b0);
    cmp(1'b1, sfrRead);
    mem_op(16'hFF28, 1'b1, 8'h6C, 1'b0);
    cmp(1'b1, sfrWrite);
    cmp({sfrOffset, sfrWdata}, 16'h286C);
    mem_op(16'hFF30, 1'b0, 8'h00, 1'b1);
    // stack push, pop and status word save
    reg_op(4'h1, 1'b1, 8'h80);
    stackWdata <= 8'hA7;
    fire(12'h080);
    cmp(8'h7F, stackPointer);
    mem_op(16'hFE7F, 1'b0, 8'hA7, 1'b0);
    fire(12'h040);
    cmp(8'hA7, stackRdata);
    cmp(8'h80, stackPointer);
    fire(12'h020);
    reg_op(4'h0, 1'b1, 8'h00);
    fire(12'h010);
    cmp(mpsw, programStatusWord);
    // flag update of every kind
    for (int k = 0; k < 12; k++) begin
      a = (k == 11) ? 8'h00 : 8'($urandom);
      b = k[0] ? -a : 8'($urandom);
      d = 8'($urandom);
      @(posedge mclk);
      aluReq <= '{gpcFlagKind_e'(k / 2), a, b, 1'b0, d[0]};
      @(posedge mclk);
      aluReq <= '0;
      #1;
      if (k / 2 == 1 || k / 2 == 2) begin
        r = (k / 2 == 1) ? {1'b0, a} + b : {1'b0, a} - b;
        mpsw[0] = r[8];
        mpsw[4] = (k / 2 == 1) ? (a[3:0] + b[3:0]) > 15 : a[3:0] < b[3:0];
        mpsw[6] = r[7:0] == 8'h00;
      end
      if (k / 2 == 3 || k / 2 == 4) mpsw[0] = d[0];
      if (k / 2 == 5) mpsw[6] = a == 8'h00;
      cmp(mpsw, programStatusWord);
    end
    // enable, disable, masked priority, then watchdog with enable clear
    reg_op(4'h0, 1'b1, 8'h00);
    fire(12'h008);
    cmp(8'h82, programStatusWord);
    fire(12'h004);
    cmp(8'h02, programStatusWord);
    maskedRequests <= 9'h028;
    fire(12'h002);
    cmp(1'b0, intAccepted);
    fire(12'h008);
    fire(12'h002);
    cmp(1'b1, intAccepted);
    cmp(4'h5, intSlot);
    cmp(8'h7F, stackPointer);
    settle();
    cmp(pcv(10), programCounter);
    mem_op(16'hFE7F, 1'b0, 8'h82, 1'b0);
    watchdogRequest <= 1'b1;
    fire(12'h002);
    watchdogRequest <= 1'b0;
    maskedRequests <= '0;
    cmp(4'h1, intSlot);
    settle();
    cmp(pcv(2), programCounter);
    // branch, advance, fixed and table calls
    p = 14'($urandom);
    pcLoadValue <= p;
    fixedOffset <= 11'($urandom);
    tableIndex <= 5'd31;
    pcAdvLen <= 3'd3;
    fire(12'h200);
    cmp(p, programCounter);
    fire(12'h100);
    cmp(14'(p + 14'd3), programCounter);
    fire(12'h400);
    cmp({3'b001, fixedOffset}, programCounter);
    fire(12'h800);
    settle();
    cmp(pcv(126), programCounter);
    complete_run();
  end
endmodule : tb
`default_nettype wire
